// ===== inc/odl_pkg.sv
package odl_pkg;
	// ----------------------------------------
	// clocking and link timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCLK_HALF_NS = 80;
	localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
	localparam int SYNC_HIGH_NS = 15;
	localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] HALF_CNT = 3'(SCLK_HALF_CYC - 1);
	localparam logic [2:0] GAP_CNT = 3'(SYNC_HIGH_CYC - 1);

	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int CODE_W = 12;
	localparam int NUM_CH = 8;
	localparam logic [5:0] FRAME_EDGES = 6'h10;
	localparam logic [5:0] MARK_EDGE = 6'h0F;
	localparam logic [5:0] EDGE_MAX = 6'h3F;
	localparam logic [5:0] CHAIN2_EDGES = 6'h20;
	localparam logic [CODE_W-1:0] CODE_RST = 12'h000;

	localparam logic [3:0] CMD_REG_ONLY = 4'h8;
	localparam logic [3:0] CMD_WRITE_THROUGH = 4'h9;
	localparam logic [3:0] CMD_UPDATE_SEL = 4'hA;
	localparam logic [3:0] CMD_CHA_WRITE = 4'hB;
	localparam logic [3:0] CMD_BROADCAST = 4'hC;

	typedef enum logic {
		ODL_REG_ONLY = 1'b0,
		ODL_WRITE_THROUGH = 1'b1
	} odl_mode_t;

	// ----------------------------------------
	// controller registers
	// ----------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] REG_DATA = 5'h00;
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h08;
	localparam logic [ADDR_W-1:0] REG_RX = 5'h0C;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_CHAIN2_BIT = 1;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ODL_IDLE = 3'b000,
		ODL_LEAD = 3'b001,
		ODL_LOW = 3'b010,
		ODL_HIGH = 3'b011,
		ODL_GAP = 3'b100
	} odl_host_st_t;
endpackage : odl_pkg

// ===== inc/odl_link_if.sv
`timescale 1ns/10ps
interface odl_link_if;
	logic sclk;
	logic sync_n;
	logic din;
	logic dout;
	modport host (output sclk, output sync_n, output din, input dout);
	modport dev (input sclk, input sync_n, input din, output dout);
endinterface : odl_link_if

// ===== src/odl_sync.sv
`timescale 1ns/10ps
module odl_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] stable_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= RST;
			stable_q <= RST;
		end else begin
			meta_q <= async_in;
			stable_q <= meta_q;
		end
	end

	assign sync_out = stable_q;
endmodule : odl_sync

// ===== src/odl_dac_end.sv
`timescale 1ns/10ps
module odl_dac_end import odl_pkg::*; (
	odl_link_if.dev link,
	input wire logic aclk,
	input wire logic aresetn,
	output logic [NUM_CH-1:0][CODE_W-1:0] reg_code,
	output logic [NUM_CH-1:0][CODE_W-1:0] out_code,
	output odl_mode_t mode,
	output logic exec_pulse,
	output logic abort_pulse
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic sclk_prev;
		logic sync_prev;
		logic [FRAME_BITS-1:0] shift;
		logic [5:0] edges;
		logic dout;
		odl_mode_t mode;
		logic [NUM_CH-1:0][CODE_W-1:0] regs;
		logic [NUM_CH-1:0][CODE_W-1:0] outs;
		logic exec;
		logic abort;
	} odl_dev_state_t;

	odl_dev_state_t q;
	odl_dev_state_t d;
	logic s_sclk;
	logic s_sync_n;
	logic s_din;
	logic sclk_fall;
	logic sync_rise;
	logic [3:0] cmd;
	logic [2:0] chan;
	logic [CODE_W-1:0] code;
	logic [NUM_CH-1:0] upd_mask;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// the three pins share one synchroniser so their relative order survives
	odl_sync #(
		.W(3),
		.RST(3'h6)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({link.sclk, link.sync_n, link.din}),
		.sync_out({s_sclk, s_sync_n, s_din})
	);

	assign sclk_fall = q.sclk_prev & ~s_sclk;
	assign sync_rise = ~q.sync_prev & s_sync_n;
	assign cmd = q.shift[FRAME_BITS-1 -: 4];
	assign chan = q.shift[14:12];
	assign code = q.shift[CODE_W-1:0];
	assign upd_mask = q.shift[NUM_CH-1:0];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.sclk_prev = s_sclk;
		d.sync_prev = s_sync_n;
		d.exec = 1'b0;
		d.abort = 1'b0;

		if (s_sync_n) begin
			// idle: counter and chain output parked
			d.edges = 6'h00;
			d.dout = 1'b0;
		end else if (sclk_fall) begin
			d.shift = {q.shift[FRAME_BITS-2:0], s_din};
			if (q.edges != EDGE_MAX) begin
				// saturates; only "sixteen or more" matters for execution
				d.edges = q.edges + 6'h01;
			end
			if (q.edges >= MARK_EDGE) begin
				// oldest bit leaves: first data bit on edge 16
				d.dout = q.shift[FRAME_BITS-2];
			end else if (q.edges == MARK_EDGE - 6'h01) begin
				d.dout = 1'b1;
			end else begin
				d.dout = 1'b0;
			end
		end

		if (sync_rise) begin
			if (q.edges < FRAME_EDGES) begin
				// too few edges: nothing changes
				d.abort = 1'b1;
			end else begin
				// last sixteen bits are this device's own command
				d.exec = 1'b1;
				if (!cmd[3]) begin
					d.regs[chan] = code;
					if (q.mode == ODL_WRITE_THROUGH) begin
						d.outs[chan] = code;
					end
				end else begin
					case (cmd)
						CMD_REG_ONLY: begin
							d.mode = ODL_REG_ONLY;
						end
						CMD_WRITE_THROUGH: begin
							d.mode = ODL_WRITE_THROUGH;
						end
						CMD_UPDATE_SEL: begin
							for (int i = 0; i < NUM_CH; i++) begin
								if (upd_mask[i]) begin
									d.outs[i] = q.regs[i];
								end
							end
						end
						CMD_CHA_WRITE: begin
							d.outs = q.regs;
							d.regs[0] = code;
							d.outs[0] = code;
						end
						CMD_BROADCAST: begin
							for (int i = 0; i < NUM_CH; i++) begin
								d.regs[i] = code;
								d.outs[i] = code;
							end
						end
						default: begin
							// unsupported codes, such as power-down, are ignored
							d.exec = 1'b1;
						end
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q.sclk_prev <= 1'b1;
			q.sync_prev <= 1'b1;
			q.shift <= '0;
			q.edges <= 6'h00;
			q.dout <= 1'b0;
			q.mode <= ODL_REG_ONLY;
			q.regs <= {NUM_CH{CODE_RST}};
			q.outs <= {NUM_CH{CODE_RST}};
			q.exec <= 1'b0;
			q.abort <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign link.dout = q.dout;
	assign reg_code = q.regs;
	assign out_code = q.outs;
	assign mode = q.mode;
	assign exec_pulse = q.exec;
	assign abort_pulse = q.abort;
endmodule : odl_dac_end

// ===== src/odl_host_end.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module odl_host_end import odl_pkg::*; (
	odl_link_if.host link,
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic aw_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic w_got;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] data;
		logic chain2;
		odl_host_st_t st;
		logic [2:0] tmr;
		logic [5:0] bits;
		logic sclk;
		logic sync_n;
		logic din;
		logic [31:0] shreg;
		logic [31:0] rx;
	} odl_host_state_t;

	odl_host_state_t q;
	odl_host_state_t d;
	logic s_dout;

	odl_sync #(
		.W(1),
		.RST(1'h0)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(link.dout),
		.sync_out(s_dout)
	);

	assign s_axi_awready = ~q.aw_got & ~q.bvalid;
	assign s_axi_wready = ~q.w_got & ~q.bvalid;
	assign s_axi_arready = ~q.rvalid;

	// ----------------------------------------
	// bus slave and frame engine
	// ----------------------------------------
	always_comb begin
		d = q;
		if (s_axi_awvalid && s_axi_awready) begin
			d.awaddr = s_axi_awaddr;
			d.aw_got = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
			d.w_got = 1'b1;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end

		if (d.aw_got && d.w_got && !q.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			case (d.awaddr)
				REG_DATA: begin
					for (int b = 0; b < 4; b++) begin
						if (d.wstrb[b]) begin
							d.data[8*b +: 8] = d.wdata[8*b +: 8];
						end
					end
				end
				REG_CTRL: begin
					// a start while a frame runs is dropped
					if (d.wstrb[0] && d.wdata[CTRL_START_BIT] && q.st == ODL_IDLE) begin
						d.chain2 = d.wdata[CTRL_CHAIN2_BIT];
						d.shreg = d.chain2 ? d.data : {d.data[15:0], 16'h0000};
						d.st = ODL_LEAD;
						d.sync_n = 1'b0;
						d.din = d.shreg[31];
						d.bits = 6'h00;
						d.tmr = HALF_CNT;
					end
				end
				REG_STATUS, REG_RX: begin
				end
				default: begin
					d.bresp = RESP_SLVERR;
				end
			endcase
		end

		if (s_axi_arvalid && s_axi_arready) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			case (s_axi_araddr)
				REG_DATA: d.rdata = q.data;
				REG_CTRL: d.rdata = {30'h0, q.chain2, 1'b0};
				REG_STATUS: d.rdata = {31'h0, q.st != ODL_IDLE};
				REG_RX: d.rdata = q.rx;
				default: begin
					d.rdata = 32'h0000_0000;
					d.rresp = RESP_SLVERR;
				end
			endcase
		end

		if (q.tmr != 3'h0) begin
			d.tmr = q.tmr - 3'h1;
		end else begin
			case (q.st)
				ODL_IDLE: begin
					// must not touch st or tmr: a start just taken from the bus set them
				end
				ODL_LEAD, ODL_HIGH: begin
					if (q.bits == (q.chain2 ? CHAIN2_EDGES : FRAME_EDGES)) begin
						// clock stays high: select rises before edge 17, or before edge 33 when chained
						d.sync_n = 1'b1;
						d.din = 1'b0;
						d.st = ODL_GAP;
						d.tmr = GAP_CNT;
					end else begin
						d.sclk = 1'b0;
						d.bits = q.bits + 6'h01;
						d.st = ODL_LOW;
						d.tmr = HALF_CNT;
					end
				end
				ODL_LOW: begin
					d.sclk = 1'b1;
					d.rx = {q.rx[30:0], s_dout};
					d.shreg = {q.shreg[30:0], 1'b0};
					d.din = q.shreg[30];
					d.st = ODL_HIGH;
					d.tmr = HALF_CNT;
				end
				ODL_GAP: begin
					d.st = ODL_IDLE;
				end
				default: begin
					d.st = ODL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.data <= DATA_RST;
			q.st <= ODL_IDLE;
			q.sclk <= 1'b1;
			q.sync_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign s_axi_bresp = q.bresp;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rvalid = q.rvalid;
	assign link.sclk = q.sclk;
	assign link.sync_n = q.sync_n;
	assign link.din = q.din;
endmodule : odl_host_end

// ===== verification/odl_link_asserts.sv
`timescale 1ns/10ps
module odl_link_asserts import odl_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic din,
	input wire logic dout
);
	// ----------
	// falling edges seen in the current frame
	// ----------
	logic [5:0] cnt_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || sync_n)
			cnt_q <= 6'h00;
		else if ($fell(sclk))
			cnt_q <= cnt_q + 6'h01;
	end
	// ----------
	// link rules
	// ----------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_sel_fall_high:
	assert property ($fell(sync_n) |-> sclk) else $error("select fell with clock low");
	a_din_hold_fall:
	assert property ($fell(sclk) |-> $stable(din)) else $error("data moved on falling edge");
	a_idle_clock_high:
	assert property (sync_n |-> sclk) else $error("clock low outside frame");
	a_idle_din_low:
	assert property (sync_n |-> !din) else $error("data high outside frame");
	a_frame_whole_words:
	assert property ($rose(sync_n) |-> cnt_q == FRAME_EDGES || cnt_q == CHAIN2_EDGES)
		else $error("frame not a multiple of sixteen edges");
	a_sel_rise_high:
	assert property ($rose(sync_n) |-> sclk && $past(sclk)) else $error("select rose badly");
	a_sel_gap_high:
	assert property ($rose(sync_n) |-> ##1 sync_n) else $error("select high too briefly");
	a_dout_lead_low:
	assert property ($fell(sclk) && cnt_q < 6'h0E |-> ##4 !dout) else $error("early dout high");
	a_dout_mark_high:
	assert property ($fell(sclk) && cnt_q == 6'h0E |-> ##[1:4] dout) else $error("no marker bit");
	a_dout_idle_low:
	assert property (sync_n [*4] |-> !dout) else $error("dout high while idle");
	c_single: cover property ($rose(sync_n) && cnt_q == FRAME_EDGES);
	c_chain: cover property ($rose(sync_n) && cnt_q == CHAIN2_EDGES);
	c_dout: cover property ($rose(dout));
endmodule : odl_link_asserts

// ===== verification/tb.sv
`timescale 1ns/10ps
module tb import odl_pkg::*; ;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [4:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [NUM_CH-1:0][CODE_W-1:0] reg_code, out_code, rc2, oc2;
	odl_mode_t mode;
	logic s2 = 1'b1, y2 = 1'b1, d2 = 1'b0, ab2, ex2;
	logic [11:0] er [8] = '{default: '0};
	logic [11:0] eo [8] = '{default: '0};
	logic em = 1'b0;
	int n_mismatch = 0, tests_run = 0, na = 0, ne = 0;
	odl_link_if lk();
	odl_link_if lk2();
	assign lk2.sclk = s2;
	assign lk2.sync_n = y2;
	assign lk2.din = d2;
	odl_host_end odl_host_end_i (.link(lk), .aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	odl_dac_end odl_dac_end_i (.link(lk), .aclk(aclk), .aresetn(aresetn),
		.reg_code(reg_code), .out_code(out_code), .mode(mode), .exec_pulse(),
		.abort_pulse());
	// second device is driven straight by the bench to break framing on purpose
	odl_dac_end odl_dac_end_i2 (.link(lk2), .aclk(aclk), .aresetn(aresetn),
		.reg_code(rc2), .out_code(oc2), .mode(), .exec_pulse(ex2), .abort_pulse(ab2));
	odl_link_asserts odl_link_asserts_i (.aclk(aclk), .aresetn(aresetn),
		.sclk(lk.sclk), .sync_n(lk.sync_n), .din(lk.din), .dout(lk.dout));
	// ----------
	// bus tasks
	// ----------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ta, tw, tr;
		logic [1:0] rs;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tr = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end while (tr !== 1'b1);
		bready <= 1'b0;
		chk(32'(rs), 32'(r));
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
		end while (tr !== 1'b1);
		rready <= 1'b0;
	endtask : rd
	// sends one frame through the controller and follows it in the model
	task automatic op(input logic [31:0] d, input logic [31:0] c);
		logic [15:0] f;
		logic [31:0] v;
		logic [1:0] r;
		f = d[15:0];
		wr(REG_DATA, d, RESP_OKAY);
		wr(REG_CTRL, c, RESP_OKAY);
		do rd(REG_STATUS, v, r); while (v[0] !== 1'b0);
		repeat (4) @(posedge aclk);
		case (f[15:12])
			CMD_REG_ONLY: em = 1'b0;
			CMD_WRITE_THROUGH: em = 1'b1;
			CMD_UPDATE_SEL: for (int i = 0; i < 8; i++) if (f[i]) eo[i] = er[i];
			CMD_CHA_WRITE: begin
				er[0] = f[11:0];
				eo = er;
			end
			CMD_BROADCAST: for (int i = 0; i < 8; i++) begin
				er[i] = f[11:0];
				eo[i] = f[11:0];
			end
			default: if (!f[15]) begin
				er[f[14:12]] = f[11:0];
				if (em)
					eo[f[14:12]] = f[11:0];
			end
		endcase
		for (int i = 0; i < NUM_CH; i++) begin
			chk(32'(reg_code[i]), 32'(er[i]));
			chk(32'(out_code[i]), 32'(eo[i]));
		end
		chk(32'(mode), 32'(em));
	endtask : op
	task automatic raw(input logic [15:0] f, input int n);
		@(posedge aclk);
		y2 <= 1'b0;
		d2 <= f[15];
		for (int k = 0; k < n; k++) begin
			repeat (4) @(posedge aclk);
			s2 <= 1'b0;
			repeat (4) @(posedge aclk);
			s2 <= 1'b1;
			d2 <= (k < 15) ? f[14-k] : 1'b0;
		end
		repeat (4) @(posedge aclk);
		y2 <= 1'b1;
		d2 <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask : raw
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	// ----------
	// sequence
	// ----------
	initial begin
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (ab2 === 1'b1)
			na <= na + 1;
		if (ex2 === 1'b1)
			ne <= ne + 1;
	end
	initial begin
		repeat (50000) @(posedge aclk);
		n_mismatch++;
		finish_test;
	end
	initial begin
		logic [31:0] v;
		logic [1:0] r;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		chk(32'(reg_code[7]), 32'h0);
		chk(32'(mode), 32'(ODL_REG_ONLY));
		for (int i = 0; i < 8; i++) op({16'h0, 1'b0, 3'(i), 12'hFFF - 12'(i)}, 32'h1);
		op(32'hA005, 32'h1);
		op(32'h9000, 32'h1);
		op(32'h35A5, 32'h1);
		op(32'hB123, 32'h1);
		op(32'h8000, 32'h1);
		op(32'h6ABC, 32'h1);
		op(32'hC800, 32'h1);
		op(32'hD123, 32'h1);
		op(32'h1234_0456, 32'h3);
		rd(REG_RX, v, r);
		// dout crosses the host's synchroniser, so each sample lags one falling edge
		chk(v, {15'h0, 1'b1, 16'h1234});
		rd(REG_CTRL, v, r);
		chk(v, 32'h2);
		wr(5'h10, 32'h1, RESP_SLVERR);
		rd(5'h10, v, r);
		chk({v[29:0], r}, {30'h0, RESP_SLVERR});
		raw(16'hC777, 14);
		chk(32'(na), 32'h1);
		raw(16'hC777, 15);
		chk(32'(na), 32'h2);
		chk(32'(rc2[5]), 32'h0);
		raw(16'hC777, 16);
		chk(32'(ne), 32'h1);
		chk(32'(oc2[5]), 32'h777);
		finish_test;
	end
endmodule : tb
